// ### rtl/dvr_regs.vh
// register offsets, field positions, reset values and codes of the volume ramp
`ifndef DVR_REGS_VH
`define DVR_REGS_VH

// register offsets
`define DVR_LEFT_VOLUME_OFS     8'h3D
`define DVR_RIGHT_VOLUME_OFS    8'h3E
`define DVR_RAMP_CONFIG_OFS     8'h3F

// reset values
`define DVR_VOLUME_RST          8'h30
`define DVR_RAMP_CONFIG_RST     8'h33

// ramp config field positions
`define DVR_DOWN_INT_HI         7
`define DVR_DOWN_INT_LO         6
`define DVR_DOWN_STEP_HI        5
`define DVR_DOWN_STEP_LO        4
`define DVR_UP_INT_HI           3
`define DVR_UP_INT_LO           2
`define DVR_UP_STEP_HI          1
`define DVR_UP_STEP_LO          0

// gain codes
`define DVR_GAIN_MUTE           8'hFF
`define DVR_GAIN_LOUDEST        8'h00

// interval codes (sample periods per update)
`define DVR_INT_1               2'h0
`define DVR_INT_2               2'h1
`define DVR_INT_4               2'h2
`define DVR_INT_INSTANT         2'h3

// step codes and their size in half-decibel code units
`define DVR_STEP_4DB            2'h0
`define DVR_STEP_2DB            2'h1
`define DVR_STEP_1DB            2'h2
`define DVR_STEP_HALF           2'h3
`define DVR_UNITS_4DB           8'h08
`define DVR_UNITS_2DB           8'h04
`define DVR_UNITS_1DB           8'h02
`define DVR_UNITS_HALF          8'h01

// link select codes
`define DVR_LINK_INDEP          2'h0
`define DVR_LINK_LEFT           2'h1

`endif

// ### rtl/dvr_skid_buf.v
// two-entry buffer with valid and ready on both sides, all outputs registered
`timescale 1ns/1ps
module dvr_skid_buf #(
    parameter W = 32
) (
    // clock and reset
    input  wire         mclk_i,
    input  wire         srst_i,
    // fill side
    input  wire         in_valid_i,
    input  wire [W-1:0] in_data_i,
    output reg          in_ready_o,
    // drain side
    output reg          out_valid_o,
    output reg  [W-1:0] out_data_o,
    input  wire         out_ready_i
);

    reg         skid_valid_q;
    reg [W-1:0] skid_data_q;
    wire        push;
    wire        pop;

    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;

    // output stage plus skid stage; ready drops once the skid holds a word
    always @(posedge mclk_i) begin
        if (srst_i) begin
            out_valid_o  <= 1'b0;
            out_data_o   <= {W{1'b0}};
            skid_valid_q <= 1'b0;
            skid_data_q  <= {W{1'b0}};
            in_ready_o   <= 1'b1;
        end else if (!out_valid_o || pop) begin
            if (skid_valid_q) begin
                out_data_o   <= skid_data_q;
                out_valid_o  <= 1'b1;
                skid_valid_q <= 1'b0;
                in_ready_o   <= 1'b1;
            end else if (push) begin
                out_data_o  <= in_data_i;
                out_valid_o <= 1'b1;
            end else begin
                out_valid_o <= 1'b0;
            end
        end else if (push) begin
            skid_data_q  <= in_data_i; // receiver stalled, keep the word
            skid_valid_q <= 1'b1;
            in_ready_o   <= 1'b0;
        end
    end

endmodule

// ### rtl/dvr_volume_ramp.v
// stereo digital volume stage with soft mute and unmute ramps
//
// Behaviour
// - left code: 0 is +24dB, 0.5dB steps, FF mutes
// - right code decodes same as left channel
// - down interval 1,2,4 periods; 11 mutes instantly
// - down step 4,2,1,0.5 dB; resets to 11
// - up interval 1,2,4 periods; 11 restores instantly
// - up step 4,2,1,0.5 dB; resets to 11
// - pin low or mute bit starts ramp down
// - pin release and bit clear start ramp up
// - ramp config resets to 00,11,00,11
// - link 01 copies left code to right
//
// how it runs
// - applied codes walk towards mute or the programmed code
// - one update per 1, 2 or 4 sample strobes, one step each
// - an unmuted target quieter than the applied code applies at once
// - link setting 01 drives the right channel from the left code
// - words taken in while a channel sits at mute carry zero there
// - sample scaling by the gain code is left to the next stage
`timescale 1ns/1ps
`include "dvr_regs.vh"
module dvr_volume_ramp (
    // clock and reset
    input  wire        mclk_i,
    input  wire        srst_i,
    // register port
    input  wire [7:0]  reg_addr_i,
    input  wire        reg_wr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    // mute and link controls
    input  wire        soft_mute_pin_n_i,
    input  wire        mute_req_i,
    input  wire [1:0]  gain_link_select_i,
    // sample timing
    input  wire        fs_stb_i,
    // sample input
    input  wire        in_valid_i,
    input  wire [15:0] in_left_i,
    input  wire [15:0] in_right_i,
    output wire        in_ready_o,
    // sample output
    output wire        out_valid_o,
    output wire [15:0] out_left_o,
    output wire [15:0] out_right_o,
    input  wire        out_ready_i,
    // applied gain codes and ramp status
    output reg  [7:0]  left_applied_o,
    output reg  [7:0]  right_applied_o,
    output reg         ramp_busy_o
);

    // programmed registers
    reg  [7:0] left_gain_code_q;
    reg  [7:0] right_gain_code_q;
    reg  [7:0] ramp_cfg_q;

    // ramp timing
    reg  [1:0] period_cnt_q;
    reg        muting_q;
    wire       muting;
    wire [1:0] down_ramp_interval;
    wire [1:0] down_ramp_step;
    wire [1:0] up_ramp_interval;
    wire [1:0] up_ramp_step;
    wire [1:0] cur_interval;
    wire [1:0] last_cnt;
    wire       update_tick;
    wire [7:0] left_target;
    wire [7:0] right_target;
    wire [7:0] left_next;
    wire [7:0] right_next;
    wire [31:0] masked_word;
    wire [31:0] out_word;

    // ramp status
    reg  [3:0] state_q;
    reg  [3:0] state_d;
    wire       down_done;
    wire       up_done;

    // one-hot ramp states
    localparam [3:0] ST_SETTLED = 4'h1; // codes sit at the target
    localparam [3:0] ST_FALLING = 4'h2; // walking towards mute
    localparam [3:0] ST_MUTED   = 4'h4; // both channels at mute
    localparam [3:0] ST_RISING  = 4'h8; // walking back to the target

    // field views of the ramp configuration
    assign down_ramp_interval =
        ramp_cfg_q[`DVR_DOWN_INT_HI:`DVR_DOWN_INT_LO];
    assign down_ramp_step = ramp_cfg_q[`DVR_DOWN_STEP_HI:`DVR_DOWN_STEP_LO];
    assign up_ramp_interval = ramp_cfg_q[`DVR_UP_INT_HI:`DVR_UP_INT_LO];
    assign up_ramp_step = ramp_cfg_q[`DVR_UP_STEP_HI:`DVR_UP_STEP_LO];

    // soft mute from either the pin or the control bit
    assign muting = ~soft_mute_pin_n_i | mute_req_i;

    // step size in half-decibel code units
    function [7:0] step_units;
        input [1:0] code;
        begin
            case (code)
                `DVR_STEP_4DB: step_units = `DVR_UNITS_4DB;
                `DVR_STEP_2DB: step_units = `DVR_UNITS_2DB;
                `DVR_STEP_1DB: step_units = `DVR_UNITS_1DB;
                default:       step_units = `DVR_UNITS_HALF;
            endcase
        end
    endfunction

    // next applied code for one channel; larger code means more attenuation
    function [7:0] ramp_next;
        input [7:0] cur;
        input [7:0] target;
        input       mute;
        input       tick;
        input [1:0] dn_int;
        input [1:0] dn_step;
        input [1:0] up_int;
        input [1:0] up_step;
        reg   [7:0] st;
        begin
            st = 8'h00;
            ramp_next = cur;
            if (mute) begin
                st = step_units(dn_step);
                if (dn_int == `DVR_INT_INSTANT) begin
                    ramp_next = `DVR_GAIN_MUTE;
                end else if (tick) begin
                    if (cur >= `DVR_GAIN_MUTE - st) begin
                        ramp_next = `DVR_GAIN_MUTE;
                    end else begin
                        ramp_next = cur + st;
                    end
                end
            end else begin
                st = step_units(up_step);
                if (up_int == `DVR_INT_INSTANT) begin
                    ramp_next = target;
                end else if (cur < target) begin
                    ramp_next = target; // quieter setting takes effect at once
                end else if (tick && cur != target) begin
                    if (cur - target <= st) begin
                        ramp_next = target;
                    end else begin
                        ramp_next = cur - st;
                    end
                end
            end
        end
    endfunction

    // interval of the active direction, as last count of the period counter
    assign cur_interval = muting ? down_ramp_interval : up_ramp_interval;
    assign last_cnt = (cur_interval == `DVR_INT_2) ? 2'd1 :
                      (cur_interval == `DVR_INT_4) ? 2'd3 : 2'd0;
    assign update_tick = fs_stb_i && (period_cnt_q >= last_cnt);

    // linked mode drives both channels from the left code
    assign left_target  = left_gain_code_q;
    assign right_target = (gain_link_select_i == `DVR_LINK_LEFT) ?
                          left_gain_code_q : right_gain_code_q;

    assign left_next = ramp_next(left_applied_o, left_target, muting,
                                 update_tick, down_ramp_interval,
                                 down_ramp_step, up_ramp_interval,
                                 up_ramp_step);
    assign right_next = ramp_next(right_applied_o, right_target, muting,
                                  update_tick, down_ramp_interval,
                                  down_ramp_step, up_ramp_interval,
                                  up_ramp_step);

    // register writes
    always @(posedge mclk_i) begin
        if (srst_i) begin
            left_gain_code_q  <= `DVR_VOLUME_RST;
            right_gain_code_q <= `DVR_VOLUME_RST;
            ramp_cfg_q        <= `DVR_RAMP_CONFIG_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `DVR_LEFT_VOLUME_OFS:  left_gain_code_q  <= reg_wdata_i;
                `DVR_RIGHT_VOLUME_OFS: right_gain_code_q <= reg_wdata_i;
                `DVR_RAMP_CONFIG_OFS:  ramp_cfg_q        <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // register reads, unmapped offsets answer zero
    always @(posedge mclk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DVR_LEFT_VOLUME_OFS:  reg_rdata_o <= left_gain_code_q;
                `DVR_RIGHT_VOLUME_OFS: reg_rdata_o <= right_gain_code_q;
                `DVR_RAMP_CONFIG_OFS:  reg_rdata_o <= ramp_cfg_q;
                default:               reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // sample-period counter; restarts when the ramp direction flips
    always @(posedge mclk_i) begin
        if (srst_i) begin
            period_cnt_q <= 2'd0;
            muting_q     <= 1'b0;
        end else begin
            muting_q <= muting;
            if (muting != muting_q) begin
                period_cnt_q <= 2'd0;
            end else if (update_tick) begin
                period_cnt_q <= 2'd0;
            end else if (fs_stb_i) begin
                period_cnt_q <= period_cnt_q + 2'd1;
            end
        end
    end

    // end points as the next applied codes will stand
    assign down_done = (left_next == `DVR_GAIN_MUTE) &&
                       (right_next == `DVR_GAIN_MUTE);
    assign up_done   = (left_next == left_target) &&
                       (right_next == right_target);

    // next ramp state; a flip of direction reverses from the current codes
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_SETTLED: begin
                if (muting) begin
                    state_d = down_done ? ST_MUTED : ST_FALLING;
                end else if (!up_done) begin
                    state_d = ST_RISING; // target moved louder
                end
            end
            ST_FALLING: begin
                if (!muting) begin
                    state_d = up_done ? ST_SETTLED : ST_RISING;
                end else if (down_done) begin
                    state_d = ST_MUTED;
                end
            end
            ST_MUTED: begin
                if (!muting) begin
                    state_d = up_done ? ST_SETTLED : ST_RISING;
                end else if (!down_done) begin
                    state_d = ST_FALLING;
                end
            end
            ST_RISING: begin
                if (muting) begin
                    state_d = down_done ? ST_MUTED : ST_FALLING;
                end else if (up_done) begin
                    state_d = ST_SETTLED;
                end
            end
            default: begin
                state_d = ST_SETTLED;
            end
        endcase
    end

    // ramp state register; leaves reset with nothing to walk
    always @(posedge mclk_i) begin
        if (srst_i) begin
            state_q <= ST_SETTLED;
        end else begin
            state_q <= state_d;
        end
    end

    // applied gain codes; start at the reset volume with no ramp pending
    always @(posedge mclk_i) begin
        if (srst_i) begin
            left_applied_o  <= `DVR_VOLUME_RST;
            right_applied_o <= `DVR_VOLUME_RST;
            ramp_busy_o     <= 1'b0;
        end else begin
            left_applied_o  <= left_next;
            right_applied_o <= right_next;
            ramp_busy_o     <= (state_d == ST_FALLING) ||
                               (state_d == ST_RISING);
        end
    end

    // silence a channel whose applied code has reached mute
    assign masked_word = {
        (left_applied_o == `DVR_GAIN_MUTE) ? 16'h0000 : in_left_i,
        (right_applied_o == `DVR_GAIN_MUTE) ? 16'h0000 : in_right_i
    };

    // a stall by the receiver back-pressures the source, no word is lost
    dvr_skid_buf #(
        .W (32)
    ) u_buf (
        .mclk_i      (mclk_i),
        .srst_i      (srst_i),
        .in_valid_i  (in_valid_i),
        .in_data_i   (masked_word),
        .in_ready_o  (in_ready_o),
        .out_valid_o (out_valid_o),
        .out_data_o  (out_word),
        .out_ready_i (out_ready_i)
    );

    assign out_left_o  = out_word[31:16];
    assign out_right_o = out_word[15:0];

endmodule

// ### tb/dvr_volume_ramp_chk.sv
// port checker of the volume ramp stage
`timescale 1ns/1ps
module dvr_chk (
    // clock, reset and controls
    input wire        mclk_i,
    input wire        srst_i,
    input wire [7:0]  reg_addr_i,
    input wire        reg_rd_i,
    input wire        soft_mute_pin_n_i,
    input wire        mute_req_i,
    input wire        fs_stb_i,
    input wire        out_ready_i,
    // observed outputs
    input wire [7:0]  reg_rdata_o,
    input wire        in_ready_o,
    input wire        out_valid_o,
    input wire [15:0] out_left_o,
    input wire [15:0] out_right_o,
    input wire [7:0]  left_applied_o,
    input wire        ramp_busy_o
);
    // muting level as the ramp sees it
    wire mute_lvl = !soft_mute_pin_n_i | mute_req_i;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // properties and their assertions
    property p_rst_codes;
        $fell(srst_i) |-> left_applied_o == 8'h30 && !ramp_busy_o;
    endproperty
    a_rst_codes: assert property (p_rst_codes)
        else $error("applied code wrong after reset");
    property p_unmapped;
        reg_rd_i && (reg_addr_i < 8'h3D || reg_addr_i > 8'h3F)
            |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_dn_mono;
        mute_lvl ##1 mute_lvl |-> left_applied_o >= $past(left_applied_o);
    endproperty
    a_dn_mono: assert property (p_dn_mono)
        else $error("gain rose while muting");
    property p_dn_step;
        mute_lvl [*2] ##1 (mute_lvl && left_applied_o != 8'hFF)
            |-> left_applied_o - $past(left_applied_o) <= 8'h08;
    endproperty
    a_dn_step: assert property (p_dn_step)
        else $error("down step above 4 dB");
    property p_mute_hold;
        mute_lvl && left_applied_o == 8'hFF |=> left_applied_o == 8'hFF;
    endproperty
    a_mute_hold: assert property (p_mute_hold)
        else $error("left left mute while muting");
    property p_fs_gate;
        mute_lvl ##1 (mute_lvl && !fs_stb_i) [*2] ##1 mute_lvl
            |-> $stable(left_applied_o) || left_applied_o == 8'hFF;
    endproperty
    a_fs_gate: assert property (p_fs_gate)
        else $error("gain moved without a sample strobe");
    property p_full;
        !in_ready_o |-> out_valid_o;
    endproperty
    a_full: assert property (p_full)
        else $error("buffer refused while output empty");
    property p_out_hold;
        out_valid_o && !out_ready_i |=> out_valid_o &&
            $stable(out_left_o) && $stable(out_right_o);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("output word changed while stalled");
    // main scenarios reached
    c_full: cover property (!in_ready_o);
    c_mute: cover property (mute_lvl && left_applied_o == 8'hFF);
    c_xfer: cover property (out_valid_o && out_ready_i);
endmodule
bind dvr_volume_ramp dvr_chk i_dvr_chk (.mclk_i, .srst_i, .reg_addr_i,
    .reg_rd_i, .soft_mute_pin_n_i, .mute_req_i, .fs_stb_i, .out_ready_i,
    .reg_rdata_o, .in_ready_o, .out_valid_o, .out_left_o, .out_right_o,
    .left_applied_o, .ramp_busy_o);

// ### tb/tb_top.sv
// self-checking bench of the volume ramp stage
`timescale 1ns/1ps
module tb_top;
    // design inputs
    reg         mclk_i = 1'b0;
    reg         srst_i = 1'b1;
    reg  [7:0]  reg_addr_i = 8'h00;
    reg         reg_wr_i = 1'b0;
    reg  [7:0]  reg_wdata_i = 8'h00;
    reg         reg_rd_i = 1'b0;
    reg         soft_mute_pin_n_i = 1'b1;
    reg         mute_req_i = 1'b0;
    reg  [1:0]  gain_link_select_i = 2'h1;
    reg         fs_stb_i = 1'b0;
    reg         in_valid_i = 1'b0;
    reg  [15:0] in_left_i = 16'h0000;
    reg  [15:0] in_right_i = 16'h0000;
    reg         out_ready_i = 1'b1;
    // design outputs
    wire [7:0]  reg_rdata_o;
    wire        in_ready_o;
    wire        out_valid_o;
    wire [15:0] out_left_o;
    wire [15:0] out_right_o;
    wire [7:0]  left_applied_o;
    wire [7:0]  right_applied_o;
    wire        ramp_busy_o;
    int         n_errors = 0;
    int         num_checks = 0;

    dvr_volume_ramp i_dvr_volume_ramp (.mclk_i, .srst_i, .reg_addr_i,
        .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
        .soft_mute_pin_n_i, .mute_req_i, .gain_link_select_i, .fs_stb_i,
        .in_valid_i, .in_left_i, .in_right_i, .in_ready_o, .out_valid_o,
        .out_left_o, .out_right_o, .out_ready_i, .left_applied_o,
        .right_applied_o, .ramp_busy_o);

    // clock at 4 ns
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    // comparisons
    task automatic chk8(input [7:0] got, input [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk16(input [15:0] got, input [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t data %h exp %h", $time, got, exp);
        end
    endtask
    // bus, strobe and stream helpers, entered just after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [7:0] e);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick(1);
        reg_rd_i = 1'b0;
        chk8(reg_rdata_o, e);
    endtask
    task automatic fs(input int n);
        repeat (n) begin
            fs_stb_i = 1'b1;
            tick(1);
            fs_stb_i = 1'b0;
            tick(1);
        end
    endtask
    task automatic send(input [15:0] l, input [15:0] r);
        in_left_i = l;
        in_right_i = r;
        in_valid_i = 1'b1;
        while (in_ready_o !== 1'b1) tick(1);
        tick(1);
        in_valid_i = 1'b0;
    endtask
    task automatic recv(input [15:0] l, input [15:0] r);
        out_ready_i = 1'b1;
        while (out_valid_o !== 1'b1) tick(1);
        chk16(out_left_o, l);
        chk16(out_right_o, r);
        tick(1);
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_errors++;
        summarize();
    end

    // main sequence
    initial begin
        tick(10);
        srst_i = 1'b0;
        rd(8'h3D, 8'h30);
        rd(8'h3E, 8'h30);
        rd(8'h3F, 8'h33);
        rd(8'h40, 8'h00);
        chk8(left_applied_o, 8'h30);
        // down ramps by register request, instant restore
        for (int i = 0; i < 3; i++) begin
            for (int s = 0; s < 4; s++) begin
                wr(8'h3F, {i[1:0], s[1:0], 4'hF});
                mute_req_i = 1'b1;
                tick(1);
                fs(12);
                chk8(left_applied_o, 8'(48 + (12 >> i) * (8 >> s)));
                chk8({7'h00, ramp_busy_o}, 8'h01);
                mute_req_i = 1'b0;
                tick(3);
                chk8(left_applied_o, 8'h30);
            end
        end
        // up ramps by the pin, instant mute
        for (int i = 0; i < 3; i++) begin
            for (int s = 0; s < 4; s++) begin
                wr(8'h3F, {4'hF, i[1:0], s[1:0]});
                soft_mute_pin_n_i = 1'b0;
                tick(3);
                chk8(left_applied_o, 8'hFF);
                soft_mute_pin_n_i = 1'b1;
                tick(1);
                fs(12);
                chk8(left_applied_o, 8'(255 - (12 >> i) * (8 >> s)));
            end
        end
        // clamping at both ends
        wr(8'h3F, 8'h00);
        mute_req_i = 1'b1;
        tick(1);
        fs(30);
        chk8(left_applied_o, 8'hFF);
        chk8(right_applied_o, 8'hFF);
        chk8({7'h00, ramp_busy_o}, 8'h00);
        mute_req_i = 1'b0;
        tick(1);
        fs(30);
        chk8(left_applied_o, 8'h30);
        // linked and independent channels
        wr(8'h3D, 8'h40);
        wr(8'h3E, 8'h50);
        tick(2);
        chk8(right_applied_o, 8'h40);
        gain_link_select_i = 2'h0;
        tick(3);
        chk8(right_applied_o, 8'h50);
        rd(8'h3E, 8'h50);
        // stream: muted word zeroed, stall fills the buffer
        wr(8'h3F, 8'hFF);
        mute_req_i = 1'b1;
        tick(3);
        out_ready_i = 1'b0;
        send(16'h1234, 16'h5678);
        mute_req_i = 1'b0;
        tick(3);
        send(16'h9ABC, 16'hDEF0);
        chk8({7'h00, in_ready_o}, 8'h00);
        recv(16'h0000, 16'h0000);
        recv(16'h9ABC, 16'hDEF0);
        chk8({7'h00, out_valid_o}, 8'h00);
        tick(2);
        summarize();
    end
endmodule
